// [hdl/mtm_timer.v]
// Purpose: 8-bit modulo timer with AXI4-Lite register access
// Assumes: One clock (bus clock); fixed clock arrives as a tick pulse
// Notes: Count tick lags the source by two cycles through prescaler and counter
//   Wait mode has no effect on counting; stop and background freeze the divider too
//   A write is answered one cycle after both address and data are taken
//
// Summary of operation
// R1: Eight-bit up-counter, free-running or modulo bounded
// R2: Four sources: bus, fixed, external rise, fall
// R3: Upper source bit set selects external input
// R4: Nine divisors, 1 through 256
// R5: Keeps counting in wait mode
// R6: Stops in stop modes, never wakes
// R7: Deep stop exit restores reset state
// R8: Shallow stop interrupt exit keeps state
// R9: Freeze in background mode, resume afterwards
// R10: External input synchronised to bus clock
// R11: External input at most quarter bus rate
// R12: Overflow flag bit 7 set on wrap
// R13: Flag clears by read-set then write-zero
// R14: Clear bit or limit write clears flag
// R15: Interrupt when flag and enable bit 6
// R16: Software clears flag before enabling interrupt
// R17: Bit 5 write-one clears count and flag
// R18: Bit 4 halts counter, set at reset
// R19: Bits 3 to 0 read zero
// R20: Four 8-bit registers exposed
// R21: Source field decode, no count clear
// R22: Prescale codes above eight divide by 256
// R23: Zero limit free-runs, write resets count
// R24: Count register read-only, resets to zero
// R25: Advance per tick when enabled and not frozen
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mtm_regs.vh"

module mtm_timer (
	input wire clock,
	input wire reset,
	input wire [3:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire external_count_input,
	input wire fixed_freq_tick,
	input wire wait_mode,
	input wire stop_mode,
	input wire deep_stop_exit,
	input wire background_mode,
	output reg overflow_irq
);

	// ************************************************************
	// Registers
	// ************************************************************
	reg overflow_flag_reg;
	reg overflow_irq_enable_reg;
	reg counter_halt_reg;
	reg [1:0] source_select_reg;
	reg [3:0] prescale_select_reg;
	reg [7:0] timer_count_value_reg;
	reg [7:0] wrap_limit_value_reg;
	reg flag_seen_reg;
	reg [3:0] aw_addr_reg;
	reg aw_held_reg;
	reg [7:0] w_data_reg;
	reg w_lane_reg;
	reg w_held_reg;
	reg ext_sync1_reg;
	reg ext_sync2_reg;
	reg ext_prev_reg;

	// ************************************************************
	// Write channel: address and data taken in either order
	// ************************************************************
	wire aw_take;
	wire w_take;
	wire do_write;
	wire [3:0] wr_addr;
	wire [7:0] wr_data;
	wire wr_lane;
	wire wr_sc;
	wire wr_clk;
	wire wr_limit;
	wire wr_mapped;
	wire counter_clear;
	wire flag_clear;

	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
	assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata[7:0];
	assign wr_lane = w_held_reg ? w_lane_reg : s_axi_wstrb[0];
	assign do_write = (aw_held_reg | aw_take) & (w_held_reg | w_take) & ~s_axi_bvalid;
	assign wr_mapped = (wr_addr[1:0] == 2'b00);
	assign wr_sc = do_write & wr_lane & (wr_addr == `MTM_OFF_STATUS_CONTROL);
	assign wr_clk = do_write & wr_lane & (wr_addr == `MTM_OFF_CLOCK_CONFIG);
	assign wr_limit = do_write & wr_lane & (wr_addr == `MTM_OFF_WRAP_LIMIT);
	assign counter_clear = (wr_sc & wr_data[`MTM_SC_COUNTER_CLEAR]) | wr_limit; // [R17] [R23]
	// Flag clears on zero write only if a previous read saw it set [R13]
	assign flag_clear = counter_clear | (wr_sc & ~wr_data[`MTM_SC_OVERFLOW_FLAG] & flag_seen_reg); // [R14]

	// Readies stay low until the response is taken, so one write is in flight
	always @(posedge clock) begin
		if (reset) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MTM_RESP_OKAY;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_data_reg <= 8'h00;
			w_lane_reg <= 1'b0;
		end else begin
			if (do_write) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_awready <= 1'b0;
				s_axi_wready <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? `MTM_RESP_OKAY : `MTM_RESP_SLVERR;
			end else begin
				if (aw_take) begin
					aw_held_reg <= 1'b1;
					aw_addr_reg <= s_axi_awaddr;
					s_axi_awready <= 1'b0;
				end
				if (w_take) begin
					w_held_reg <= 1'b1;
					w_data_reg <= s_axi_wdata[7:0];
					w_lane_reg <= s_axi_wstrb[0];
					s_axi_wready <= 1'b0;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Read channel
	// ************************************************************
	reg [7:0] rd_byte;
	reg rd_ok;
	wire rd_take;
	wire rd_sc;

	// Unmapped offsets answer with an error and zero data
	assign rd_take = s_axi_arvalid & s_axi_arready;
	assign rd_sc = rd_take & (s_axi_araddr == `MTM_OFF_STATUS_CONTROL);

	always @* begin
		rd_byte = 8'h00;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`MTM_OFF_STATUS_CONTROL: begin
				// Clear bit and bits 3:0 always read zero [R17] [R19]
				rd_byte = {overflow_flag_reg, overflow_irq_enable_reg, 1'b0, counter_halt_reg, 4'h0};
			end
			`MTM_OFF_CLOCK_CONFIG: begin
				rd_byte = {2'b00, source_select_reg, prescale_select_reg};
			end
			`MTM_OFF_COUNT_VALUE: begin
				rd_byte = timer_count_value_reg; // [R24]
			end
			`MTM_OFF_WRAP_LIMIT: begin
				rd_byte = wrap_limit_value_reg;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	always @(posedge clock) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `MTM_RESP_OKAY;
		end else begin
			if (rd_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_byte}; // [R20]
				s_axi_rresp <= rd_ok ? `MTM_RESP_OKAY : `MTM_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ************************************************************
	// External input and source selection
	// ************************************************************
	// Input must stay at or below a quarter of the bus rate so no edge is missed [R11]
	// Edge detect reads the second stage and its delayed copy, never the first
	always @(posedge clock) begin
		if (reset) begin
			ext_sync1_reg <= 1'b0;
			ext_sync2_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
		end else begin
			ext_sync1_reg <= external_count_input; // [R10]
			ext_sync2_reg <= ext_sync1_reg;
			ext_prev_reg <= ext_sync2_reg;
		end
	end

	// Bus source ticks every cycle, so divide by 1 runs at the bus rate
	reg source_tick;
	always @* begin
		case (source_select_reg) // [R2] [R21]
			`MTM_SRC_BUS: source_tick = 1'b1;
			`MTM_SRC_FIXED: source_tick = fixed_freq_tick;
			`MTM_SRC_EXT_FALL: source_tick = ext_prev_reg & ~ext_sync2_reg; // [R3]
			`MTM_SRC_EXT_RISE: source_tick = ~ext_prev_reg & ext_sync2_reg; // [R3]
			default: source_tick = 1'b1;
		endcase
	end

	// Wait mode deliberately does not gate counting [R5]
	wire run;
	wire count_tick;
	assign run = ~counter_halt_reg & ~stop_mode & ~background_mode; // [R6] [R9] [R18] [R25]

	mtm_prescaler u_prescaler (
		.clock(clock),
		.reset(reset | deep_stop_exit),
		.source_tick(source_tick),
		.run(run),
		.prescale_select(prescale_select_reg),
		.count_tick(count_tick)
	);

	// ************************************************************
	// Counter, flag and control registers
	// ************************************************************
	wire soft_reset;
	wire wrap_hit;
	wire wrap_event;
	wire [7:0] wrap_value;
	reg [7:0] timer_count_value_next;
	reg overflow_flag_next;
	reg flag_seen_next;

	// Deep stop exit, or a shallow stop left by reset, arrives as this restore [R7]
	assign soft_reset = reset | deep_stop_exit;
	// A zero limit lets the count run through FF before it wraps [R23]
	assign wrap_value = (wrap_limit_value_reg == 8'h00) ? 8'hFF : wrap_limit_value_reg;
	assign wrap_hit = (timer_count_value_reg == wrap_value); // [R1]
	// A halt written in the same cycle as a tick still lets that tick count
	assign wrap_event = count_tick & run & wrap_hit;

	// ************************************************************
	// Next values of count, flag and read marker
	// ************************************************************
	// Clear beats a tick in the same cycle [R17] [R23]
	always @* begin
		timer_count_value_next = timer_count_value_reg;
		if (counter_clear) begin
			timer_count_value_next = 8'h00;
		end else if (count_tick && run) begin
			if (wrap_hit) begin
				timer_count_value_next = 8'h00; // [R1]
			end else begin
				timer_count_value_next = timer_count_value_reg + 8'h01; // [R25]
			end
		end
	end

	// Wrap sets the flag and wins over a same-cycle clear [R12]
	always @* begin
		overflow_flag_next = overflow_flag_reg;
		if (wrap_event) begin
			overflow_flag_next = 1'b1;
		end else if (flag_clear) begin
			overflow_flag_next = 1'b0; // [R13] [R14]
		end
	end

	// A fresh wrap asks for a fresh read before a zero write clears it [R13]
	always @* begin
		flag_seen_next = flag_seen_reg;
		if (flag_clear || wrap_event) begin
			flag_seen_next = 1'b0;
		end else if (rd_sc && overflow_flag_reg) begin
			flag_seen_next = 1'b1;
		end
	end

	always @(posedge clock) begin
		if (soft_reset) begin
			overflow_flag_reg <= 1'b0;
			overflow_irq_enable_reg <= 1'b0; // [R15]
			counter_halt_reg <= `MTM_RST_HALT; // [R18]
			source_select_reg <= `MTM_RST_SOURCE;
			prescale_select_reg <= `MTM_RST_PRESCALE;
			timer_count_value_reg <= `MTM_RST_COUNT; // [R24]
			wrap_limit_value_reg <= `MTM_RST_WRAP_LIMIT;
			flag_seen_reg <= 1'b0;
			overflow_irq <= 1'b0;
		end else begin
			// State persists through shallow stop and background freeze [R8] [R9]
			if (wr_sc) begin
				overflow_irq_enable_reg <= wr_data[`MTM_SC_IRQ_ENABLE];
				counter_halt_reg <= wr_data[`MTM_SC_COUNTER_HALT]; // [R18]
			end
			if (wr_clk) begin
				source_select_reg <= wr_data[`MTM_CLK_SRC_HI:`MTM_CLK_SRC_LO]; // [R21]
				prescale_select_reg <= wr_data[`MTM_CLK_PS_HI:`MTM_CLK_PS_LO]; // [R22]
			end
			if (wr_limit) begin
				wrap_limit_value_reg <= wr_data;
			end
			timer_count_value_reg <= timer_count_value_next; // [R1] [R25]
			overflow_flag_reg <= overflow_flag_next; // [R12]
			flag_seen_reg <= flag_seen_next; // [R13]
			// Software should clear the flag before enabling [R16]
			overflow_irq <= overflow_flag_reg & overflow_irq_enable_reg; // [R15]
		end
	end

endmodule
`default_nettype wire

// [hdl/mtm_regs.vh]
// Purpose: Constants for the 8-bit modulo timer block
// Assumes: Register map reached over AXI4-Lite, one aligned word per register
// Notes: Offsets are byte addresses
`ifndef MTM_REGS_VH
`define MTM_REGS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define MTM_OFF_STATUS_CONTROL 4'h0
`define MTM_OFF_CLOCK_CONFIG 4'h4
`define MTM_OFF_COUNT_VALUE 4'h8
`define MTM_OFF_WRAP_LIMIT 4'hC

// ************************************************************
// Field positions
// ************************************************************
`define MTM_SC_OVERFLOW_FLAG 7
`define MTM_SC_IRQ_ENABLE 6
`define MTM_SC_COUNTER_CLEAR 5
`define MTM_SC_COUNTER_HALT 4
`define MTM_CLK_SRC_HI 5
`define MTM_CLK_SRC_LO 4
`define MTM_CLK_PS_HI 3
`define MTM_CLK_PS_LO 0

// ************************************************************
// Reset values and encodings
// ************************************************************
`define MTM_RST_HALT 1'b1
`define MTM_RST_SOURCE 2'h0
`define MTM_RST_PRESCALE 4'h0
`define MTM_RST_COUNT 8'h00
`define MTM_RST_WRAP_LIMIT 8'h00
`define MTM_SRC_BUS 2'h0
`define MTM_SRC_FIXED 2'h1
`define MTM_SRC_EXT_FALL 2'h2
`define MTM_SRC_EXT_RISE 2'h3
`define MTM_PS_MAX 4'h8
`define MTM_RESP_OKAY 2'h0
`define MTM_RESP_SLVERR 2'h2

`endif

// [hdl/mtm_prescaler.v]
// Purpose: Prescaler of the modulo timer, divides source ticks by 1 to 256
// Assumes: Source ticks are one-cycle pulses on the bus clock
// Notes: Divider is never cleared by a select change
`timescale 1ns/1ps
`default_nettype none
`include "mtm_regs.vh"

module mtm_prescaler (
	input wire clock,
	input wire reset,
	input wire source_tick,
	input wire run,
	input wire [3:0] prescale_select,
	output reg count_tick
);

	reg [7:0] div_reg;
	wire [7:0] div_next;
	wire [8:0] carry;
	wire [3:0] ps_eff;

	// Codes above eight act as divide by 256 [R22]
	assign ps_eff = (prescale_select > `MTM_PS_MAX) ? `MTM_PS_MAX : prescale_select;
	assign div_next = div_reg + 8'h01;

	// Carry out of bit n marks a source count that is a multiple of 2^(n+1) [R4]
	assign carry[0] = 1'b1;
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_carry
			assign carry[i+1] = carry[i] & div_reg[i];
		end
	endgenerate

	always @(posedge clock) begin
		if (reset) begin
			div_reg <= 8'h00;
			count_tick <= 1'b0;
		end else begin
			count_tick <= 1'b0;
			// Frozen with the counter so that resume is exact [R25]
			if (run && source_tick) begin
				div_reg <= div_next;
				count_tick <= carry[ps_eff];
			end
		end
	end

endmodule
`default_nettype wire

// [test/mtm_timer_asserts.sv]
// Purpose: Port-level checks for the modulo timer
// Assumes: One clock, synchronous active-high reset
// Notes: Attached to every timer instance by bind
`timescale 1ns/1ps
`default_nettype none
`include "mtm_regs.vh"

module mtm_timer_asserts (
	input wire logic clock,
	input wire logic reset,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic deep_stop_exit,
	input wire logic overflow_irq
);
	// ********************
	// Checks
	// ********************
	wire ar_take = s_axi_arvalid && s_axi_arready;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	AST_B_NEXT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	AST_R_NEXT: assert property (ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_SC_ZERO: assert property (ar_take && s_axi_araddr == 4'h0 |=> !s_axi_rdata[5] && s_axi_rdata[3:0] == 4'h0)
		else $error("status blank bits set");
	AST_CLK_ZERO: assert property (ar_take && s_axi_araddr == 4'h4 |=> s_axi_rdata[7:6] == 2'h0)
		else $error("config blank bits set");
	AST_BAD_ADDR: assert property (ar_take && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == `MTM_RESP_SLVERR)
		else $error("unmapped read not refused");
	AST_DEEP_IRQ: assert property (deep_stop_exit |-> ##2 !overflow_irq)
		else $error("interrupt kept over deep stop");
	AST_IRQ_START: assert property ($fell(reset) |-> !overflow_irq)
		else $error("interrupt high out of reset");
endmodule

bind mtm_timer mtm_timer_asserts u_chk (.clock, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .deep_stop_exit, .overflow_irq);
`default_nettype wire

// [test/mtm_timer_tb.sv]
// Purpose: Self-checking bench for the modulo timer
// Assumes: Fixed ticks and external input come from here
// Notes: Responses are queued and judged by a monitor
`timescale 1ns/1ps
`default_nettype none

module mtm_timer_tb;
	logic clock = 1'h0, reset = 1'h1;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, external_count_input = 1'h0, fixed_freq_tick = 1'h0;
	logic wait_mode = 1'h0, stop_mode = 1'h0, deep_stop_exit = 1'h0, background_mode = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, overflow_irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [7:0] lf_s = 8'h4D, lim;
	int n_checks = 0, n_mismatch = 0, cnt = 0;

	mtm_timer uut (.clock, .reset, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.external_count_input, .fixed_freq_tick, .wait_mode, .stop_mode, .deep_stop_exit, .background_mode,
		.overflow_irq);

	// ********************
	// Helpers
	// ********************
	always #5 clock = ~clock;

	function automatic logic [7:0] lf();
		lf_s = {lf_s[6:0], lf_s[7] ^ lf_s[5] ^ lf_s[4] ^ lf_s[3]};
		return lf_s;
	endfunction

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'h0;
		w_done = 1'h0;
		bq.push_back(r);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw_done && w_done)) begin
			@(posedge clock);
			aw_done |= s_axi_awvalid && s_axi_awready;
			w_done |= s_axi_wvalid && s_axi_wready;
			s_axi_awvalid <= !aw_done;
			s_axi_wvalid <= !w_done;
		end
		do @(posedge clock); while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [9:0] e);
		rq.push_back({e[9:8], 24'h0, e[7:0]});
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clock); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clock); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
	endtask

	// Each tick is one cycle high, then low for one or two cycles at random
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clock) fixed_freq_tick <= 1'h1;
			@(posedge clock) fixed_freq_tick <= 1'h0;
			repeat (lf() % 2) @(posedge clock);
		end
		repeat (4) @(posedge clock);
	endtask

	// Eight-cycle period keeps the pin under a quarter of the bus rate
	task automatic edge_in(input int n);
		repeat (2 * n) begin
			repeat (4) @(posedge clock);
			external_count_input <= !external_count_input;
		end
		repeat (6) @(posedge clock);
	endtask

	always @(posedge clock) begin
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
	end

	initial begin
		#400000;
		n_mismatch++;
		close_out();
	end

	// ********************
	// Scenarios
	// ********************
	initial begin
		repeat (16) @(posedge clock);
		reset <= 1'h0;
		rd(4'h0, 10'h010);
		rd(4'h4, 10'h000);
		rd(4'h8, 10'h000);
		rd(4'hC, 10'h000);
		rd(4'h2, 10'h200);
		wr(4'h1, 8'hFF, 2'h2);
		wr(4'h4, 8'h10, 2'h0);
		wr(4'h0, 8'h20, 2'h0);
		for (int ps = 0; ps < 16; ps++) begin
			wr(4'h4, {4'h1, ps[3:0]}, 2'h0);
			pulse(2 * (ps > 8 ? 256 : 1 << ps));
			cnt += 2;
			rd(4'h8, {2'h0, cnt[7:0]});
		end
		wr(4'h8, 8'h55, 2'h0);
		rd(4'h8, {2'h0, cnt[7:0]});
		wr(4'h4, 8'h10, 2'h0);
		@(posedge clock) stop_mode <= 1'h1;
		pulse(3);
		@(posedge clock) stop_mode <= 1'h0;
		@(posedge clock) background_mode <= 1'h1;
		pulse(3);
		@(posedge clock) background_mode <= 1'h0;
		rd(4'h8, {2'h0, cnt[7:0]});
		@(posedge clock) wait_mode <= 1'h1;
		pulse(2);
		cnt += 2;
		rd(4'h8, {2'h0, cnt[7:0]});
		wr(4'h0, 8'h10, 2'h0);
		pulse(3);
		rd(4'h8, {2'h0, cnt[7:0]});
		wr(4'h0, 8'h00, 2'h0);
		wr(4'h4, 8'h30, 2'h0);
		edge_in(3);
		wr(4'h4, 8'h20, 2'h0);
		edge_in(3);
		cnt += 6;
		rd(4'h8, {2'h0, cnt[7:0]});
		wr(4'h4, 8'h10, 2'h0);
		lim = 8'h2 + lf() % 4;
		wr(4'hC, lim, 2'h0);
		rd(4'h8, 10'h000);
		pulse(lim + 1);
		rd(4'h0, 10'h080);
		rd(4'h8, 10'h000);
		chk({33'h0, overflow_irq}, 34'h0);
		wr(4'h0, 8'h40, 2'h0);
		rd(4'h0, 10'h040);
		pulse(lim + 1);
		repeat (3) @(posedge clock);
		chk({33'h0, overflow_irq}, 34'h1);
		rd(4'h0, 10'h0C0);
		wr(4'h0, 8'h40, 2'h0);
		rd(4'h0, 10'h040);
		chk({33'h0, overflow_irq}, 34'h0);
		pulse(lim + 1);
		wr(4'h0, 8'h40, 2'h0);
		rd(4'h0, 10'h0C0);
		wr(4'h0, 8'h40, 2'h0);
		rd(4'h0, 10'h040);
		pulse(lim + 1);
		wr(4'h0, 8'h60, 2'h0);
		rd(4'h0, 10'h040);
		rd(4'h8, 10'h000);
		pulse(lim + 1);
		wr(4'hC, 8'h00, 2'h0);
		rd(4'h0, 10'h040);
		pulse(256);
		rd(4'h0, 10'h0C0);
		@(posedge clock) deep_stop_exit <= 1'h1;
		@(posedge clock) deep_stop_exit <= 1'h0;
		rd(4'h0, 10'h010);
		rd(4'h4, 10'h000);
		repeat (4) @(posedge clock);
		close_out();
	end
endmodule
`default_nettype wire
